// ===== design/mrs_regs.svh
`ifndef MRS_REGS_SVH
`define MRS_REGS_SVH

`define MRS_FN_COILS    8'h01
`define MRS_FN_HOLD     8'h03
`define MRS_FN_INPUT    8'h04
`define MRS_FN_EXEC     8'h05
`define MRS_FN_SINGLE   8'h06
`define MRS_FN_STATUS   8'h07
`define MRS_FN_LOOP     8'h08
`define MRS_FN_MULTI    8'h10
`define MRS_EXC_FLAG    8'h80
`define MRS_EXC_FUNC    8'h01
`define MRS_EXC_VALUE   8'h03
`define MRS_BCAST       8'h00
`define MRS_EXEC_ON     16'hff00
`define MRS_MAX_REGS    16'h007d
`define MRS_MAX_COILS   16'h07d0
`define MRS_OP_NONE     16'h0000
`define MRS_CRC_PRESET  16'hffff
`define MRS_CRC_POLY    16'ha001
`define MRS_GAP_HALF_10 8'h46
`define MRS_GAP_HALF_11 8'h4d
`define MRS_MIN_FRAME   9'h004
`define MRS_MULTI_FRAME 9'h00b
`define MRS_HDR_LEN     16'h0003
`define MRS_ECHO_LEN    16'h0006

`endif

// ===== design/mrs_pkg.sv
package mrs_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_SEND, ST_CRC_LO, ST_CRC_HI, ST_DRAIN} mrs_state_t;
	typedef enum logic [1:0] {MD_EXC, MD_ECHO, MD_BITS, MD_REGS} mrs_mode_t;
endpackage

// ===== design/mrs_crc_if.sv
`timescale 1ns/100ps
interface mrs_crc_if;
	logic        clr;
	logic        en;
	logic [7:0]  data;
	logic [15:0] crc;
	modport eng  (input clr, input en, input data, output crc);
	modport user (output clr, output en, output data, input crc);
endinterface

// ===== design/mrs_crc16.sv
`timescale 1ns/100ps
`include "mrs_regs.svh"
module mrs_crc16 (
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	mrs_crc_if.eng    cif
);
	logic [15:0] crc_q;
	logic [15:0] crc_d;
	logic [15:0] base;

	function automatic logic [15:0] mrs_step(input logic [15:0] acc, input logic [7:0] b);
		logic [15:0] a;
		a = acc ^ {8'h00, b};
		for (int k = 0; k < 8; k++) begin
			a = a[0] ? ((a >> 1) ^ `MRS_CRC_POLY) : (a >> 1); // [RL1] [RL2]
		end
		return a;
	endfunction

	// Clear and feed may coincide so the first byte of a frame costs no extra cycle
	assign base  = cif.clr ? `MRS_CRC_PRESET : crc_q; // [RL1]
	assign crc_d = cif.en ? mrs_step(base, cif.data) : base;
	assign cif.crc = crc_q;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			crc_q <= `MRS_CRC_PRESET;
		end else begin
			crc_q <= crc_d;
		end
	end

	AST_CRC_PRESET: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL1]
		cif.clr && !cif.en |=> crc_q == `MRS_CRC_PRESET) else $error("crc not preset");
	AST_CRC_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL2]
		!cif.clr && !cif.en |=> $stable(crc_q)) else $error("crc moved while idle");
endmodule

// ===== design/mrs_slave.sv
// Functional notes
// RL1: CRC preset all ones, shift right per byte
// RL2: Generator is reflected polynomial, data bits only
// RL3: 3.5 character silence ends or abandons frame
// RL4: Bad CRC request gets no reply
// RL5: Act on own or broadcast address only
// RL6: Accept functions 01,03,04,05,06,07,08,10 only
// RL7: Errors reply address, function+128, code, CRC
// RL8: Remember last operation executed by 05
// RL9: Function 01 returns one bit per operation
// RL10: Operation zero set before any execution
// RL11: Byte count first, LSB-first, zero padding
// RL12: Functions 03/04 send 16-bit registers MSB first
// RL13: Master sends start then count, high first
// RL14: More than 125 registers is invalid
// RL15: Register reply carries byte count twice registers
// RL16: Function 04 identical to 03 except code
// RL17: Function 05 value FF00 executes, echo request
// RL18: Function 10 can also trigger operations
// RL19: Character time is 10 or 11 bits
// RL20: Reply only after full frame validated
`timescale 1ns/100ps
`include "mrs_regs.svh"
module mrs_slave #(
	parameter int          DEPTH    = 16,
	parameter logic [15:0] CMD_ADDR = 16'h0080
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  slave_addr_i,
	input  wire logic [15:0] bit_div_i,
	input  wire logic        parity_en_i,
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_data_i,
	output logic             tx_valid_o,
	output logic [7:0]       tx_data_o,
	input  wire logic        tx_ready_i,
	output logic             tx_busy_o,
	output logic [15:0]      reg_addr_o,
	input  wire logic [15:0] reg_data_i,
	output logic             op_exec_o,
	output logic [15:0]      op_code_o,
	output logic [15:0]      last_op_o,
	output logic             aux_req_o,
	output logic [7:0]       aux_func_o
);
	mrs_crc_if crc ();
	mrs_crc16 u_crc (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cif(crc));

	mrs_pkg::mrs_state_t state_q;
	mrs_pkg::mrs_mode_t  mode_q;
	mrs_pkg::mrs_mode_t  mode_d;
	logic [7:0]  buf_q [DEPTH];
	logic [8:0]  idx_q;
	logic        open_q;
	logic [15:0] clk_cnt_q;
	logic [7:0]  half_cnt_q;
	logic [15:0] pos_q;
	logic [15:0] len_q;
	logic [15:0] len_d;
	logic [15:0] rd_addr_q;
	logic [7:0]  lo_q;
	logic [7:0]  exc_q;
	logic [7:0]  exc_d;
	logic [7:0]  tx_data_q;
	logic        tx_valid_q;
	logic [15:0] last_op_q;
	logic [15:0] op_code_q;
	logic        op_exec_q;
	logic        aux_req_q;
	logic [7:0]  aux_func_q;

	// Silence timer in half-bit units so that 3.5 characters is a whole count
	wire [15:0] half_div  = (bit_div_i > 16'h0003) ? (bit_div_i >> 1) : 16'h0001;
	wire        half_tick = (clk_cnt_q >= half_div - 16'h0001);
	wire [7:0]  gap_thr   = parity_en_i ? `MRS_GAP_HALF_11 : `MRS_GAP_HALF_10; // [RL19]
	wire        gap_hit   = open_q && (half_cnt_q == gap_thr) && !rx_valid_i; // [RL3]
	wire        rx_take   = rx_valid_i && (state_q == mrs_pkg::ST_IDLE); // [RL20]

	wire [7:0]  fn   = buf_q[1];
	wire [15:0] w2   = {buf_q[2], buf_q[3]}; // [RL13]
	wire [15:0] w4   = {buf_q[4], buf_q[5]};
	wire        is_reg   = (fn == `MRS_FN_HOLD) || (fn == `MRS_FN_INPUT); // [RL16]
	wire        is_aux   = (fn == `MRS_FN_SINGLE) || (fn == `MRS_FN_STATUS) || (fn == `MRS_FN_LOOP);
	wire        supported = is_reg || is_aux || (fn == `MRS_FN_COILS) || (fn == `MRS_FN_EXEC)
		|| (fn == `MRS_FN_MULTI); // [RL6]
	wire        addr_ok  = (buf_q[0] == slave_addr_i) || (buf_q[0] == `MRS_BCAST); // [RL5]
	wire        bcast    = (buf_q[0] == `MRS_BCAST);
	wire        frame_ok = (idx_q >= `MRS_MIN_FRAME) && (crc.crc == 16'h0000) && addr_ok; // [RL4]
	wire        regs_bad = (w4 == 16'h0000) || (w4 > `MRS_MAX_REGS); // [RL14]
	wire        coil_bad = (w4 == 16'h0000) || (w4 > `MRS_MAX_COILS);
	wire        exec5    = (fn == `MRS_FN_EXEC) && (w4 == `MRS_EXEC_ON); // [RL17]
	wire        exec10   = (fn == `MRS_FN_MULTI) && (w2 == CMD_ADDR) && (idx_q >= `MRS_MULTI_FRAME); // [RL18]
	wire [15:0] exec_op  = exec10 ? {buf_q[7], buf_q[8]} : w2;
	wire [15:0] nbytes   = (w4 + 16'h0007) >> 3;
	wire        silent   = is_aux || bcast;

	assign exc_d = !supported ? `MRS_EXC_FUNC : `MRS_EXC_VALUE; // [RL7]
	assign mode_d = (!supported || (is_reg && regs_bad) || ((fn == `MRS_FN_COILS) && coil_bad)
		|| ((fn == `MRS_FN_EXEC) && !exec5)) ? mrs_pkg::MD_EXC :
		(fn == `MRS_FN_COILS) ? mrs_pkg::MD_BITS :
		is_reg ? mrs_pkg::MD_REGS : mrs_pkg::MD_ECHO;
	assign len_d = (mode_d == mrs_pkg::MD_EXC)  ? `MRS_HDR_LEN :
		(mode_d == mrs_pkg::MD_BITS) ? `MRS_HDR_LEN + nbytes :
		(mode_d == mrs_pkg::MD_REGS) ? `MRS_HDR_LEN + {w4[14:0], 1'b0} : `MRS_ECHO_LEN; // [RL15]

	// Coil byte: bit i stands for operation start + 8*byte + i
	wire [15:0] boff = pos_q - `MRS_HDR_LEN;
	wire [15:0] bbase = w2 + {boff[12:0], 3'b000};
	wire [7:0]  bits_byte;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_bit
			wire [15:0] rel = {boff[12:0], 3'b000} + 16'(gi);
			assign bits_byte[gi] = (rel < w4) && (bbase + 16'(gi) == last_op_q); // [RL9] [RL11]
		end
	endgenerate

	wire [7:0] hdr_byte = (pos_q == 16'h0000) ? slave_addr_i : // [RL5]
		(mode_q == mrs_pkg::MD_EXC) ? fn | `MRS_EXC_FLAG : fn; // [RL7]
	wire [7:0] cnt_byte = (mode_q == mrs_pkg::MD_EXC) ? exc_q :
		(mode_q == mrs_pkg::MD_BITS) ? nbytes[7:0] :
		(mode_q == mrs_pkg::MD_REGS) ? {w4[6:0], 1'b0} : buf_q[2]; // [RL11] [RL15]
	wire [7:0] body_byte = (mode_q == mrs_pkg::MD_BITS) ? bits_byte :
		(mode_q == mrs_pkg::MD_REGS) ? (pos_q[0] ? reg_data_i[15:8] : lo_q) : // [RL12]
		buf_q[pos_q[2:0]]; // [RL17]
	wire [7:0] tx_next = (pos_q < 16'h0002) ? hdr_byte : (pos_q == 16'h0002) ? cnt_byte : body_byte;
	wire       load    = (state_q == mrs_pkg::ST_SEND) && !tx_valid_q && (pos_q != len_q);

	assign crc.clr  = (rx_take && !open_q) || (state_q == mrs_pkg::ST_CHECK);
	assign crc.en   = rx_take || load;
	assign crc.data = load ? tx_next : rx_data_i;

	assign tx_valid_o = tx_valid_q;
	assign tx_data_o  = tx_data_q;
	assign tx_busy_o  = (state_q != mrs_pkg::ST_IDLE) && (state_q != mrs_pkg::ST_CHECK);
	assign reg_addr_o = rd_addr_q;
	assign op_exec_o  = op_exec_q;
	assign op_code_o  = op_code_q;
	assign last_op_o  = last_op_q;
	assign aux_req_o  = aux_req_q;
	assign aux_func_o = aux_func_q;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			clk_cnt_q  <= 16'h0000;
			half_cnt_q <= 8'h00;
		end else if (rx_valid_i || !open_q) begin
			clk_cnt_q  <= 16'h0000;
			half_cnt_q <= 8'h00;
		end else if (half_tick) begin
			clk_cnt_q  <= 16'h0000;
			half_cnt_q <= (half_cnt_q == gap_thr) ? half_cnt_q : half_cnt_q + 8'h01;
		end else begin
			clk_cnt_q  <= clk_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			open_q <= 1'b0;
			idx_q  <= 9'h000;
		end else if (rx_take) begin
			open_q <= 1'b1;
			idx_q  <= open_q ? ((idx_q == 9'h1ff) ? idx_q : idx_q + 9'h001) : 9'h001;
		end else if (gap_hit) begin
			open_q <= 1'b0; // [RL3]
		end
	end

	// Bytes past the buffer still enter the CRC; only the leading ones are decoded
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_buf
			wire wr = rx_take && ((open_q && idx_q == 9'(gi)) || (!open_q && gi == 0));
			always_ff @(posedge clk_sys_i or posedge rst_i) begin
				if (rst_i) begin
					buf_q[gi] <= 8'h00;
				end else if (wr) begin
					buf_q[gi] <= rx_data_i;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_q    <= mrs_pkg::ST_IDLE;
			mode_q     <= mrs_pkg::MD_EXC;
			exc_q      <= 8'h00;
			len_q      <= 16'h0000;
			pos_q      <= 16'h0000;
			rd_addr_q  <= 16'h0000;
			lo_q       <= 8'h00;
			tx_valid_q <= 1'b0;
			tx_data_q  <= 8'h00;
			last_op_q  <= `MRS_OP_NONE; // [RL10]
			op_code_q  <= 16'h0000;
			op_exec_q  <= 1'b0;
			aux_req_q  <= 1'b0;
			aux_func_q <= 8'h00;
		end else begin
			op_exec_q <= 1'b0;
			aux_req_q <= 1'b0;
			if (tx_valid_q && tx_ready_i) begin
				tx_valid_q <= 1'b0;
			end
			unique case (state_q)
				mrs_pkg::ST_IDLE: begin
					if (gap_hit) begin
						state_q <= mrs_pkg::ST_CHECK;
					end
				end
				mrs_pkg::ST_CHECK: begin
					pos_q     <= 16'h0000;
					mode_q    <= mode_d;
					exc_q     <= exc_d;
					len_q     <= len_d;
					rd_addr_q <= w2;
					if (frame_ok && (exec5 || exec10)) begin
						op_exec_q <= 1'b1;
						op_code_q <= exec_op;
						last_op_q <= exec_op; // [RL8] [RL18]
					end
					if (frame_ok && is_aux) begin
						aux_req_q  <= 1'b1;
						aux_func_q <= fn;
					end
					state_q <= (frame_ok && !silent) ? mrs_pkg::ST_SEND : mrs_pkg::ST_IDLE; // [RL4] [RL20]
				end
				mrs_pkg::ST_SEND: begin
					if (load) begin
						tx_data_q  <= tx_next;
						tx_valid_q <= 1'b1;
						pos_q      <= pos_q + 16'h0001;
						if (mode_q == mrs_pkg::MD_REGS && pos_q >= `MRS_HDR_LEN) begin
							if (pos_q[0]) begin
								lo_q <= reg_data_i[7:0];
							end else begin
								rd_addr_q <= rd_addr_q + 16'h0001;
							end
						end
					end else if (!tx_valid_q) begin
						state_q <= mrs_pkg::ST_CRC_LO;
					end
				end
				mrs_pkg::ST_CRC_LO: begin
					if (!tx_valid_q) begin
						tx_data_q  <= crc.crc[7:0];
						tx_valid_q <= 1'b1;
						state_q    <= mrs_pkg::ST_CRC_HI;
					end
				end
				mrs_pkg::ST_CRC_HI: begin
					if (!tx_valid_q) begin
						tx_data_q  <= crc.crc[15:8];
						tx_valid_q <= 1'b1;
						state_q    <= mrs_pkg::ST_DRAIN;
					end
				end
				mrs_pkg::ST_DRAIN: begin
					if (!tx_valid_q) begin
						state_q <= mrs_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	AST_GAP_ENDS_FRAME: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL3]
		$fell(open_q) |-> state_q == mrs_pkg::ST_CHECK) else $error("frame closed without silence");
	AST_BAD_CRC_SILENT: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL4]
		state_q == mrs_pkg::ST_CHECK && crc.crc != 16'h0000 |=> state_q == mrs_pkg::ST_IDLE)
		else $error("reply to bad crc");
	AST_REPLY_ADDR: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL5]
		tx_valid_o && state_q == mrs_pkg::ST_SEND && pos_q == 16'h0001 |-> tx_data_o == slave_addr_i)
		else $error("reply address wrong");
	AST_UNSUPPORTED: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL6]
		state_q == mrs_pkg::ST_CHECK && frame_ok && !supported |=> mode_q == mrs_pkg::MD_EXC
		&& exc_q == `MRS_EXC_FUNC) else $error("unsupported code not refused");
	AST_EXC_CODE: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL7]
		tx_valid_o && state_q == mrs_pkg::ST_SEND && mode_q == mrs_pkg::MD_EXC && pos_q == 16'h0002
		|-> tx_data_o == (fn | `MRS_EXC_FLAG)) else $error("exception function wrong");
	AST_LAST_OP: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL8]
		op_exec_o |-> last_op_o == op_code_o ##1 last_op_o == $past(op_code_o))
		else $error("last operation lost");
	AST_REG_LIMIT: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL14]
		state_q == mrs_pkg::ST_CHECK && is_reg && w4 > `MRS_MAX_REGS |=> mode_q == mrs_pkg::MD_EXC)
		else $error("oversize read accepted");
	AST_REG_COUNT: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL15]
		tx_valid_o && state_q == mrs_pkg::ST_SEND && mode_q == mrs_pkg::MD_REGS && pos_q == 16'h0003
		|-> tx_data_o == {w4[6:0], 1'b0}) else $error("byte count wrong");
	AST_ECHO: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL17]
		tx_valid_o && state_q == mrs_pkg::ST_SEND && mode_q == mrs_pkg::MD_ECHO && pos_q == 16'h0005
		|-> tx_data_o == buf_q[4]) else $error("echo mismatch");
	AST_HALF_DUPLEX: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RL20]
		tx_valid_o |-> tx_busy_o && !open_q) else $error("send while receiving");
endmodule

// ===== sim/mrs_master.sv
`timescale 1ns/100ps
module mrs_master (
	input  wire logic       clk_sys_i,
	output logic            rx_valid_o,
	output logic [7:0]      rx_data_o,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            tx_ready_o,
	input  wire logic       tx_busy_i
);
	logic [7:0] q[$];
	bit         slow = 0;
	int         cyc = 0;
	int         t_last = 0;
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o  = 8'h00;
		tx_ready_o = 1'b0;
	end
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (tx_valid_i && tx_ready_o)
			q.push_back(tx_data_i);
	end
	// Sparse ready in slow mode makes the reply byte stand for several cycles
	always @(negedge clk_sys_i)
		tx_ready_o <= slow ? (cyc % 3 == 0) : 1'b1;
	function automatic logic [15:0] crc16(logic [7:0] b[$]);
		logic [15:0] a;
		a = 16'hffff;
		foreach (b[i]) begin
			a[7:0] = a[7:0] ^ b[i];
			repeat (8) a = a[0] ? (a >> 1) ^ 16'ha001 : a >> 1;
		end
		return a;
	endfunction
	task automatic send(logic [71:0] v, int n, bit crc, bit bad);
		logic [7:0]  b[$];
		logic [15:0] c;
		for (int i = n - 1; i >= 0; i--)
			b.push_back(v[8*i +: 8]);
		c = crc16(b) ^ {15'h0000, bad};
		if (crc) begin
			b.push_back(c[7:0]);
			b.push_back(c[15:8]);
		end
		q.delete();
		foreach (b[i]) begin
			@(negedge clk_sys_i);
			rx_valid_o = 1'b1;
			rx_data_o  = b[i];
			@(negedge clk_sys_i);
			rx_valid_o = 1'b0;
			rx_data_o  = ~b[i];
			t_last     = cyc;
			repeat (14) @(negedge clk_sys_i);
		end
	endtask
	task automatic get(output int n, output int lat);
		int w;
		n   = 0;
		lat = 0;
		w   = 0;
		while (!tx_busy_i && w < 600) begin
			@(posedge clk_sys_i);
			#1 w++;
		end
		if (!tx_busy_i)
			return;
		lat = cyc - t_last;
		w   = 0;
		while (tx_busy_i && w < 8000) begin
			@(posedge clk_sys_i);
			#1 w++;
		end
		n = q.size();
	endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/100ps
module testbench;
	typedef struct {
		logic [71:0] rq;
		int          ql;
		logic [71:0] rs;
		int          rl;
		int          ex;
		logic [15:0] lo;
	} mrs_row_t;
	logic        clk_sys_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        par = 1'b0;
	logic        rxv, txv, txr, busy, opx, auxr;
	logic [7:0]  rxd, txd, auxf;
	logic [15:0] raddr, opc, lop;
	int          errors = 0, checked = 0, nx = 0, na = 0, n, lat;
	mrs_row_t    t;
	logic [7:0]  af[3] = '{8'h06, 8'h07, 8'h08};
	mrs_row_t    rows[16] = '{
		'{72'h1101_0000_0008, 6, 72'h1101_0101, 4, 0, 16'h0000},
		'{72'h1105_000d_ff00, 6, 72'h1105_000d_ff00, 6, 1, 16'h000d},
		'{72'h1101_000a_0006, 6, 72'h1101_0108, 4, 1, 16'h000d},
		'{72'h1101_0005_000a, 6, 72'h1101_0200_01, 5, 1, 16'h000d},
		'{72'h1103_006b_0003, 6, 72'h1103_06_6b94_6c93_6d92, 9, 1, 16'h000d},
		'{72'h1104_0008_0001, 6, 72'h1104_02_08f7, 5, 1, 16'h000d},
		'{72'h1102_0000_0001, 6, 72'h1182_01, 3, 1, 16'h000d},
		'{72'h117f_0000_0001, 6, 72'h11ff_01, 3, 1, 16'h000d},
		'{72'h1103_0000_007e, 6, 72'h1183_03, 3, 1, 16'h000d},
		'{72'h1105_0002_0000, 6, 72'h1185_03, 3, 1, 16'h000d},
		'{72'h1205_0002_ff00, 6, 72'h0, 0, 1, 16'h000d},
		'{72'h0005_0003_ff00, 6, 72'h0, 0, 2, 16'h0003},
		'{72'h1101_0000_0008, 6, 72'h1101_0108, 4, 2, 16'h0003},
		'{72'h1110_0080_0001_02_0007, 9, 72'h1110_0080_0001, 6, 3, 16'h0007},
		'{72'h1110_0100_0001_02_0009, 9, 72'h1110_0100_0001, 6, 3, 16'h0007},
		'{72'h1101_0000_0010, 6, 72'h1101_0280_00, 5, 3, 16'h0007}};
	always #10 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		if (opx) nx++;
		if (auxr) na++;
	end
	// Register stand-in: each address below 256 yields a distinct word
	mrs_slave #(.DEPTH(16), .CMD_ADDR(16'h0080)) mrs_slave_i (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .slave_addr_i(8'h11), .bit_div_i(16'h0008),
		.parity_en_i(par), .rx_valid_i(rxv), .rx_data_i(rxd), .tx_valid_o(txv), .tx_data_o(txd),
		.tx_ready_i(txr), .tx_busy_o(busy), .reg_addr_o(raddr), .reg_data_i({raddr[7:0], ~raddr[7:0]}),
		.op_exec_o(opx), .op_code_o(opc), .last_op_o(lop), .aux_req_o(auxr), .aux_func_o(auxf));
	mrs_master mrs_master_i (
		.clk_sys_i(clk_sys_i), .rx_valid_o(rxv), .rx_data_o(rxd), .tx_valid_i(txv), .tx_data_i(txd),
		.tx_ready_o(txr), .tx_busy_i(busy));
	task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wrap_up;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic run(mrs_row_t r, bit bad);
		mrs_master_i.send(r.rq, r.ql, 1'b1, bad);
		mrs_master_i.get(n, lat);
		chk("reply length", 16'(n), 16'(r.rl + (r.rl > 0 ? 2 : 0)));
		for (int i = 0; i < r.rl && i < n; i++)
			chk("reply byte", {8'h00, mrs_master_i.q[i]}, {8'h00, r.rs[8*(r.rl-1-i) +: 8]});
		if (n > 0)
			chk("reply crc", mrs_master_i.crc16(mrs_master_i.q), 16'h0000);
		chk("exec count", 16'(nx), 16'(r.ex));
		chk("last op", lop, r.lo);
	endtask
	initial begin
		repeat (6) @(negedge clk_sys_i);
		chk("reset busy", {15'h0000, busy}, 16'h0000);
		chk("reset last op", lop, 16'h0000);
		rst_i = 1'b0;
		foreach (rows[i]) begin
			mrs_master_i.slow = i % 2;
			run(rows[i], 1'b0);
		end
		chk("op code", opc, 16'h0007);
		// A corrupted check word must neither answer nor execute
		t = '{72'h1105_0009_ff00, 6, 72'h0, 0, 3, 16'h0007};
		run(t, 1'b1);
		// Zero counts draw a value exception rather than an empty reply
		t = '{72'h1101_0000_0000, 6, 72'h1181_03, 3, 3, 16'h0007};
		run(t, 1'b0);
		t = '{72'h1104_0000_0000, 6, 72'h1184_03, 3, 3, 16'h0007};
		run(t, 1'b0);
		mrs_master_i.send(72'h1105_000a_ff, 5, 1'b0, 1'b0);
		mrs_master_i.get(n, lat);
		chk("partial frame", 16'(n), 16'h0000);
		run(rows[15], 1'b0);
		chk("gap ten bits", {15'h0000, lat > 279 && lat < 293}, 16'h0001);
		@(negedge clk_sys_i);
		par = 1'b1;
		run(rows[15], 1'b0);
		chk("gap eleven bits", {15'h0000, lat > 307 && lat < 321}, 16'h0001);
		foreach (af[i]) begin
			t = '{{24'h000000, 8'h11, af[i], 32'h1020_01f4}, 6, 72'h0, 0, 3, 16'h0007};
			run(t, 1'b0);
			chk("aux count", 16'(na), 16'(i + 1));
			chk("aux func", {8'h00, auxf}, {8'h00, af[i]});
		end
		// Reset in mid-run forgets the last operation
		@(negedge clk_sys_i);
		rst_i = 1'b1;
		nx    = 0;
		@(negedge clk_sys_i);
		rst_i = 1'b0;
		run(rows[0], 1'b0);
		wrap_up();
	end
	initial begin
		#1_200_000;
		errors++;
		wrap_up();
	end
endmodule
